// File: shared/dsbwm_defines.svh
// constants of the write lane masking block: widths, register map, field positions
// assumes inclusion by the package and the design files by bare name
`ifndef DSBWM_DEFINES_SVH
`define DSBWM_DEFINES_SVH

`define DSBWM_DW 36
`define DSBWM_LANES 4
`define DSBWM_LANE_W 9
`define DSBWM_NIB_W 4
`define DSBWM_AW 3
`define DSBWM_WAW 4
`define DSBWM_DEPTH 16

`define DSBWM_OFS_CTRL 8'h00
`define DSBWM_OFS_STATUS 8'h04
`define DSBWM_OFS_MEMIDX 8'h08
`define DSBWM_OFS_MEMDATA 8'h0C

`define DSBWM_CTRL_ORG_LSB 0
`define DSBWM_CTRL_SINGLE_BIT 2
`define DSBWM_CTRL_RESET 3'h3
`define DSBWM_ST_WPEND_BIT 0
`define DSBWM_ST_OE_BIT 1
`define DSBWM_ST_RPEND_BIT 2
`define DSBWM_ST_CNT_LSB 16

`define DSBWM_MASK_X8_LO 36'h00000000F
`define DSBWM_MASK_X8_HI 36'h0000000F0
`define DSBWM_MASK_LANE0 36'h0000001FF
`define DSBWM_MASK_LANE1 36'h00003FE00
`define DSBWM_MASK_LANE2 36'h007FC0000
`define DSBWM_MASK_LANE3 36'hFF8000000
`define DSBWM_MASK_X18 36'h00003FFFF
`define DSBWM_MASK_ALL 36'hFFFFFFFFF

`endif

// File: shared/dsbwm_pkg.sv
// types of the write lane masking block
// assumes the defines header is on the include path
`include "dsbwm_defines.svh"

package dsbwm_pkg;

  typedef enum logic [1:0] {
    ORG_X8 = 2'b00,
    ORG_X9 = 2'b01,
    ORG_X18 = 2'b10,
    ORG_X36 = 2'b11
  } dsbwm_org_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_SECOND = 1'b1
  } dsbwm_rd_state_t;

  typedef struct packed {
    logic in_clk;
    logic in_clk_n;
    logic out_clk;
    logic out_clk_n;
    logic load_strobe_n;
    logic rw_read;
    logic [`DSBWM_AW-1:0] addr;
    logic [`DSBWM_DW-1:0] data;
    logic [`DSBWM_LANES-1:0] byte_lane_select_n;
  } dsbwm_pins_t;

  typedef struct packed {
    logic we;
    logic [`DSBWM_WAW-1:0] addr;
    logic [`DSBWM_DW-1:0] data;
    logic [`DSBWM_DW-1:0] mask;
  } dsbwm_wr_t;

endpackage

// File: logic/dsbwm_lane_ram.sv
// flip-flop word array with a bit-masked write port and two read ports
// assumes one write per cycle; reads are combinational
`timescale 1ns/1ps
`default_nettype none
`include "dsbwm_defines.svh"

module dsbwm_lane_ram (
  input wire logic hclk,
  input wire logic hresetn,
  input wire dsbwm_pkg::dsbwm_wr_t wr,
  input wire logic [`DSBWM_WAW-1:0] raddr_a,
  output logic [`DSBWM_DW-1:0] rdata_a,
  input wire logic [`DSBWM_WAW-1:0] raddr_b,
  output logic [`DSBWM_DW-1:0] rdata_b
);

  logic [`DSBWM_DW-1:0] mem_q [`DSBWM_DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < `DSBWM_DEPTH; gi++) begin : g_word
      // disabled lanes keep their bits, even when the beat lands long after its command
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mem_q[gi] <= '0;
        end else if (wr.we && wr.addr == `DSBWM_WAW'(gi)) begin
          mem_q[gi] <= (mem_q[gi] & ~wr.mask) | (wr.data & wr.mask);
        end
      end
    end
  endgenerate

  assign rdata_a = mem_q[raddr_a];
  assign rdata_b = mem_q[raddr_b];

  property p_merge;
    @(posedge hclk) disable iff (!hresetn)
    wr.we |=> mem_q[$past(wr.addr)] ==
      (($past(mem_q[wr.addr]) & ~$past(wr.mask)) | ($past(wr.data) & $past(wr.mask)));
  endproperty
  a_merge: assert property (p_merge) else $error("masked merge wrong");

endmodule
`default_nettype wire

// File: logic/dsbwm_top.sv
// double-rate synchronous sram write path with lane masking, read launch and ahb-lite access
// assumes pins come from another clock domain; hclk samples the link clocks at 8x or more
//
// Contract
// - x8/x18: both selects low store whole beat
// - select 0 only: store lower lane only
// - select 1 only: store upper lane only
// - x8/x18: both selects high, nothing stored
// - x9: single select gates the whole beat
// - x36: all selects low store 36 bits
// - x36: select 0 alone stores bits 8..0
// - x36: select 1 alone stores bits 17..9
// - x36: select 2 alone stores bits 26..18
// - x36: select 3 alone stores bits 35..27
// - x9/x36: all selects high, no update
// - selects sampled separately on every beat
// - powers up deselected, outputs off until read
// - beats go to base then base plus one
// - data cycles count from command cycle t
// - data and selects taken on both clock rises
// - reads launch on output clocks, or input clocks
// - beat one at k, beat two at k-bar
`timescale 1ns/1ps
`default_nettype none
`include "dsbwm_defines.svh"

module dsbwm_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic in_clk,
  input wire logic in_clk_n,
  input wire logic out_clk,
  input wire logic out_clk_n,
  input wire logic load_strobe_n,
  input wire logic rw_read,
  input wire logic [`DSBWM_AW-1:0] addr,
  input wire logic [`DSBWM_DW-1:0] data_in,
  input wire logic [`DSBWM_LANES-1:0] byte_lane_select_n,
  output logic [`DSBWM_DW-1:0] data_out,
  output logic data_out_oe
);

  // lane enables per organisation; a high select keeps that lane
  function automatic logic [`DSBWM_DW-1:0] lane_mask(dsbwm_pkg::dsbwm_org_t org,
                                                      logic [`DSBWM_LANES-1:0] sel_n);
    logic [`DSBWM_DW-1:0] m;
    int i;
    m = '0;
    unique case (org)
      dsbwm_pkg::ORG_X8: begin
        m[`DSBWM_NIB_W-1:0] = {`DSBWM_NIB_W{~sel_n[0]}};
        m[2*`DSBWM_NIB_W-1:`DSBWM_NIB_W] = {`DSBWM_NIB_W{~sel_n[1]}};
      end
      dsbwm_pkg::ORG_X9: begin
        m[`DSBWM_LANE_W-1:0] = {`DSBWM_LANE_W{~sel_n[0]}};
      end
      dsbwm_pkg::ORG_X18: begin
        for (i = 0; i < 2; i++) begin
          m[i*`DSBWM_LANE_W +: `DSBWM_LANE_W] = {`DSBWM_LANE_W{~sel_n[i]}};
        end
      end
      dsbwm_pkg::ORG_X36: begin
        for (i = 0; i < `DSBWM_LANES; i++) begin
          m[i*`DSBWM_LANE_W +: `DSBWM_LANE_W] = {`DSBWM_LANE_W{~sel_n[i]}};
        end
      end
    endcase
    return m;
  endfunction

  // pin synchronisers; only the second stage feeds logic
  dsbwm_pkg::dsbwm_pins_t pins, s1_q, s2_q;
  logic [3:0] clk_prev_q;
  assign pins = '{in_clk, in_clk_n, out_clk, out_clk_n, load_strobe_n, rw_read, addr,
                  data_in, byte_lane_select_n};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // parked high so a clock already high at release does not fake an edge
      s1_q <= '{in_clk: 1'b1, in_clk_n: 1'b1, out_clk: 1'b1, out_clk_n: 1'b1,
                load_strobe_n: 1'b1, rw_read: 1'b0, default: '0};
      s2_q <= '{in_clk: 1'b1, in_clk_n: 1'b1, out_clk: 1'b1, out_clk_n: 1'b1,
                load_strobe_n: 1'b1, rw_read: 1'b0, default: '0};
      clk_prev_q <= 4'hF;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      clk_prev_q <= {s2_q.in_clk, s2_q.in_clk_n, s2_q.out_clk, s2_q.out_clk_n};
    end
  end

  logic k_rise, kn_rise, c_rise, cn_rise, out_p_rise, out_n_rise;
  assign k_rise = s2_q.in_clk & ~clk_prev_q[3];
  assign kn_rise = s2_q.in_clk_n & ~clk_prev_q[2];
  assign c_rise = s2_q.out_clk & ~clk_prev_q[1];
  assign cn_rise = s2_q.out_clk_n & ~clk_prev_q[0];

  // control register
  logic [2:0] ctrl_q;
  dsbwm_pkg::dsbwm_org_t org;
  logic single_mode;
  assign org = dsbwm_pkg::dsbwm_org_t'(ctrl_q[`DSBWM_CTRL_ORG_LSB +: 2]);
  assign single_mode = ctrl_q[`DSBWM_CTRL_SINGLE_BIT];
  assign out_p_rise = single_mode ? k_rise : c_rise;
  assign out_n_rise = single_mode ? kn_rise : cn_rise;

  // command decode at the true input clock rise, cycle t
  logic wr_cmd, rd_cmd;
  assign wr_cmd = k_rise && !s2_q.load_strobe_n && !s2_q.rw_read;
  assign rd_cmd = k_rise && !s2_q.load_strobe_n && s2_q.rw_read;

  // write tracking: command pending for beat 0, then beat 1 pending
  logic wr_pend_q, b1_pend_q;
  logic [`DSBWM_AW-1:0] wr_addr_q, b1_addr_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      b1_pend_q <= 1'b0;
      b1_addr_q <= '0;
    end else begin
      // a new command in the same k rise as the previous beat 0 overlaps cleanly
      if (wr_cmd) begin
        wr_pend_q <= 1'b1;
        wr_addr_q <= s2_q.addr;
      end else if (k_rise) begin
        wr_pend_q <= 1'b0;
      end
      if (k_rise && wr_pend_q) begin
        b1_pend_q <= 1'b1;
        b1_addr_q <= wr_addr_q;
      end else if (kn_rise) begin
        b1_pend_q <= 1'b0;
      end
    end
  end

  // each beat takes its own selects, so masks may differ within a burst
  dsbwm_pkg::dsbwm_wr_t wr;
  logic beat0, beat1;
  logic [`DSBWM_DW-1:0] beat_mask;
  assign beat0 = k_rise && wr_pend_q;
  assign beat1 = kn_rise && b1_pend_q;
  assign beat_mask = lane_mask(org, s2_q.byte_lane_select_n);
  assign wr.mask = beat_mask;
  assign wr.data = s2_q.data;
  assign wr.addr = beat0 ? {wr_addr_q, 1'b0} : {b1_addr_q, 1'b1};
  assign wr.we = (beat0 || beat1) && (beat_mask != '0);

  logic [`DSBWM_WAW-1:0] rd_word;
  logic [`DSBWM_DW-1:0] rdata_a, rdata_b;
  logic [`DSBWM_WAW-1:0] memidx_q;

  dsbwm_lane_ram u_ram (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr(wr),
    .raddr_a(rd_word),
    .rdata_a(rdata_a),
    .raddr_b(memidx_q),
    .rdata_b(rdata_b)
  );

  // read path: base word on the falling-phase clock, next word on the following rise
  logic rq_pend_q;
  logic [`DSBWM_AW-1:0] rq_addr_q, ro_addr_q;
  dsbwm_pkg::dsbwm_rd_state_t rd_state_q;
  assign rd_word = (rd_state_q == dsbwm_pkg::RD_SECOND) ? {ro_addr_q, 1'b1} : {rq_addr_q, 1'b0};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rq_pend_q <= 1'b0;
      rq_addr_q <= '0;
    end else if (rd_cmd) begin
      rq_pend_q <= 1'b1;
      rq_addr_q <= s2_q.addr;
    end else if (out_n_rise) begin
      rq_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_state_q <= dsbwm_pkg::RD_IDLE;
      ro_addr_q <= '0;
      data_out <= '0;
      data_out_oe <= 1'b0;
    end else if (out_n_rise && rq_pend_q) begin
      rd_state_q <= dsbwm_pkg::RD_SECOND;
      ro_addr_q <= rq_addr_q;
      data_out <= rdata_a;
      data_out_oe <= 1'b1;
    end else if (out_p_rise) begin
      unique case (rd_state_q)
        dsbwm_pkg::RD_SECOND: begin
          data_out <= rdata_a;
          rd_state_q <= dsbwm_pkg::RD_IDLE;
        end
        dsbwm_pkg::RD_IDLE: begin
          data_out_oe <= 1'b0;
        end
      endcase
    end
  end

  // stored beat counter, wraps
  logic [15:0] beat_cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      beat_cnt_q <= '0;
    end else if (wr.we) begin
      beat_cnt_q <= beat_cnt_q + 16'h0001;
    end
  end

  // ahb-lite slave, zero wait states, read data prepared at the address phase
  logic ap_take;
  logic [7:0] ap_ofs;
  logic wdp_q;
  logic [7:0] wofs_q;
  assign ap_take = hsel && hready && htrans[1];
  assign ap_ofs = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdp_q <= 1'b0;
      wofs_q <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wdp_q <= ap_take && hwrite;
      wofs_q <= ap_ofs;
      if (ap_take && !hwrite) begin
        unique case (ap_ofs)
          `DSBWM_OFS_CTRL: hrdata <= {29'h0, ctrl_q};
          `DSBWM_OFS_STATUS: hrdata <= {beat_cnt_q, 13'h0, rq_pend_q, data_out_oe,
                                        wr_pend_q | b1_pend_q};
          `DSBWM_OFS_MEMIDX: hrdata <= {28'h0, memidx_q};
          `DSBWM_OFS_MEMDATA: hrdata <= rdata_b[31:0];
          default: hrdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `DSBWM_CTRL_RESET;
      memidx_q <= '0;
    end else if (wdp_q) begin
      if (wofs_q == `DSBWM_OFS_CTRL) begin
        ctrl_q <= hwdata[2:0];
      end
      if (wofs_q == `DSBWM_OFS_MEMIDX) begin
        memidx_q <= hwdata[`DSBWM_WAW-1:0];
      end
    end
  end

  // checks
  logic rd_seen_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_seen_q <= 1'b0;
    end else if (rd_cmd) begin
      rd_seen_q <= 1'b1;
    end
  end

  property p_quiet_until_read;
    @(posedge hclk) disable iff (!hresetn) !rd_seen_q |-> !data_out_oe;
  endproperty
  a_quiet_until_read: assert property (p_quiet_until_read) else $error("driven before read");

  property p_x18_full;
    @(posedge hclk) disable iff (!hresetn)
    (beat0 || beat1) && org == dsbwm_pkg::ORG_X18 && s2_q.byte_lane_select_n[1:0] == 2'b00
      |-> wr.we && wr.mask == `DSBWM_MASK_X18;
  endproperty
  a_x18_full: assert property (p_x18_full) else $error("x18 full beat mask wrong");

  property p_lower_only;
    @(posedge hclk) disable iff (!hresetn)
    (beat0 || beat1) && s2_q.byte_lane_select_n[1:0] == 2'b10
      |-> (org == dsbwm_pkg::ORG_X8 && wr.mask == `DSBWM_MASK_X8_LO) ||
          (org == dsbwm_pkg::ORG_X18 && wr.mask == `DSBWM_MASK_LANE0) ||
          org == dsbwm_pkg::ORG_X9 || org == dsbwm_pkg::ORG_X36;
  endproperty
  a_lower_only: assert property (p_lower_only) else $error("lower lane mask wrong");

  property p_upper_only;
    @(posedge hclk) disable iff (!hresetn)
    (beat0 || beat1) && s2_q.byte_lane_select_n[1:0] == 2'b01 && org == dsbwm_pkg::ORG_X8
      |-> wr.mask == `DSBWM_MASK_X8_HI;
  endproperty
  a_upper_only: assert property (p_upper_only) else $error("upper nibble mask wrong");

  property p_none_written;
    @(posedge hclk) disable iff (!hresetn)
    (beat0 || beat1) && &s2_q.byte_lane_select_n |-> !wr.we;
  endproperty
  a_none_written: assert property (p_none_written) else $error("write with lanes off");

  property p_x9_gate;
    @(posedge hclk) disable iff (!hresetn)
    (beat0 || beat1) && org == dsbwm_pkg::ORG_X9
      |-> wr.we == !s2_q.byte_lane_select_n[0] && wr.mask[35:9] == 27'h0;
  endproperty
  a_x9_gate: assert property (p_x9_gate) else $error("x9 gate wrong");

  property p_x36_lane3;
    @(posedge hclk) disable iff (!hresetn)
    (beat0 || beat1) && org == dsbwm_pkg::ORG_X36 && s2_q.byte_lane_select_n == 4'h7
      |-> wr.mask == `DSBWM_MASK_LANE3;
  endproperty
  a_x36_lane3: assert property (p_x36_lane3) else $error("lane 3 mask wrong");

  property p_x36_lane12;
    @(posedge hclk) disable iff (!hresetn)
    (beat0 || beat1) && org == dsbwm_pkg::ORG_X36 && s2_q.byte_lane_select_n inside {4'hD, 4'hB}
      |-> wr.mask == (s2_q.byte_lane_select_n == 4'hD ? `DSBWM_MASK_LANE1 : `DSBWM_MASK_LANE2);
  endproperty
  a_x36_lane12: assert property (p_x36_lane12) else $error("lane 1 or 2 mask wrong");

  property p_burst_order;
    @(posedge hclk) disable iff (!hresetn)
    beat0 && wr.we ##1 (!kn_rise)[*1] |-> $past(wr.addr, 2) == {wr_addr_q, 1'b0} || wr_cmd ||
      $past(wr.addr, 2) == {b1_addr_q, 1'b0};
  endproperty
  a_burst_order: assert property (p_burst_order) else $error("beat 0 address wrong");

  property p_second_beat;
    @(posedge hclk) disable iff (!hresetn)
    beat0 |=> b1_pend_q;
  endproperty
  a_second_beat: assert property (p_second_beat) else $error("second beat not armed");

  property p_beat1_addr;
    @(posedge hclk) disable iff (!hresetn)
    beat1 |-> wr.addr == {b1_addr_q, 1'b1} ##1 !b1_pend_q || $past(k_rise);
  endproperty
  a_beat1_addr: assert property (p_beat1_addr) else $error("second beat address wrong");

  property p_read_launch;
    @(posedge hclk) disable iff (!hresetn)
    out_n_rise && rq_pend_q |=> data_out_oe && rd_state_q == dsbwm_pkg::RD_SECOND;
  endproperty
  a_read_launch: assert property (p_read_launch) else $error("read not launched");

endmodule
`default_nettype wire

// File: logic/dsbwm_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: verif/dsbwm_ctrl_model.sv
// behavioural memory controller on the far side of the link pins
// assumes hclk edges fall 7 ns after each link edge; callers start on an hclk rise
`timescale 1ns/1ps
`default_nettype none

module dsbwm_ctrl_model (
  output logic in_clk,
  output logic in_clk_n,
  output logic out_clk,
  output logic out_clk_n,
  output logic load_strobe_n,
  output logic rw_read,
  output logic [2:0] addr,
  output logic [35:0] data_in,
  output logic [3:0] byte_lane_select_n
);
  // output clocks follow the input pair with zero skew, so both read modes behave alike
  assign out_clk = in_clk;
  assign out_clk_n = in_clk_n;

  // clocks parked high between frames, so a restart needs no recharge
  initial begin
    in_clk = 1'b1;
    in_clk_n = 1'b1;
    load_strobe_n = 1'b1;
    rw_read = 1'b0;
    addr = 3'h0;
    data_in = 36'h0;
    byte_lane_select_n = 4'hF;
  end

  // one burst frame; data moves mid-phase so each rise sees stable lines
  task automatic burst(input logic rd, input logic [2:0] a, input logic [35:0] d0,
                       input logic [3:0] s0, input logic [35:0] d1, input logic [3:0] s1);
    #13 in_clk = 1'b0;
    load_strobe_n = 1'b0;
    rw_read = rd;
    addr = a;
    #80 in_clk = 1'b1;
    in_clk_n = 1'b0;
    #50 load_strobe_n = 1'b1;
    addr = ~a;
    data_in = d0;
    byte_lane_select_n = s0;
    #30 in_clk = 1'b0;
    in_clk_n = 1'b1;
    #80 in_clk = 1'b1;
    in_clk_n = 1'b0;
    #50 data_in = d1;
    byte_lane_select_n = s1;
    #30 in_clk = 1'b0;
    in_clk_n = 1'b1;
    // released lines show the inverse, never the stale beat
    #50 data_in = ~d1;
    byte_lane_select_n = ~s1;
    #30 in_clk = 1'b1;
    in_clk_n = 1'b0;
    repeat (2) begin
      #80 in_clk = 1'b0;
      in_clk_n = 1'b1;
      #80 in_clk = 1'b1;
      in_clk_n = 1'b0;
    end
    #80 in_clk_n = 1'b1;
  endtask
endmodule

`default_nettype wire

// File: verif/tb.sv
// self-checking bench: ahb-lite master, link controller model, reference memory
// assumes the design answers ahb with zero wait and merges each beat at once
`timescale 1ns/1ps
`default_nettype none
`include "dsbwm_defines.svh"

module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, data_out_oe, cap_en;
  logic in_clk, in_clk_n, out_clk, out_clk_n, load_strobe_n, rw_read;
  logic [31:0] haddr, hwdata, hrdata, r, seed;
  logic [1:0] htrans;
  logic [2:0] hsize, addr;
  logic [35:0] data_in, data_out;
  logic [3:0] byte_lane_select_n;
  logic [35:0] mem [16];
  logic [35:0] capq [$];
  int n_mismatch, comparisons, cnt;

  dsbwm_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .in_clk(in_clk),
    .in_clk_n(in_clk_n), .out_clk(out_clk), .out_clk_n(out_clk_n),
    .load_strobe_n(load_strobe_n), .rw_read(rw_read), .addr(addr), .data_in(data_in),
    .byte_lane_select_n(byte_lane_select_n), .data_out(data_out),
    .data_out_oe(data_out_oe));

  dsbwm_ctrl_model ctl (.in_clk(in_clk), .in_clk_n(in_clk_n), .out_clk(out_clk),
    .out_clk_n(out_clk_n), .load_strobe_n(load_strobe_n), .rw_read(rw_read),
    .addr(addr), .data_in(data_in), .byte_lane_select_n(byte_lane_select_n));

  always #10 hclk = ~hclk;

  // sampled on the falling edge, well away from the register updates
  always @(negedge hclk) begin
    if (cap_en && data_out_oe === 1'b1 && (capq.size() == 0 || data_out !== capq[$]))
      capq.push_back(data_out);
  end

  task automatic complete_run();
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // wait for hready at a rising edge; read data are taken at that same edge
  task automatic wt(output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        n_mismatch++;
        complete_run();
      end
      @(posedge hclk);
    end
    rd = hrdata;
    chk("hresp", 36'h0, {35'h0, hresp});
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wt(rd);
    htrans <= 2'b00;
    hwdata <= wd;
    wt(rd);
  endtask

  // reference lane map: x8 two nibbles, x9 one lane, x18 two, x36 four
  function automatic logic [35:0] lane_mask(input int o, input logic [3:0] s);
    int nl, lw;
    lane_mask = 36'h0;
    nl = (o == 1) ? 1 : (o == 3) ? 4 : 2;
    lw = (o == 0) ? 4 : 9;
    for (int i = 0; i < nl; i++)
      if (!s[i]) lane_mask |= ((36'h1 << lw) - 36'h1) << (i * lw);
  endfunction

  // only bits 31:0 of a word are visible, so lane 3 is checked in part
  task automatic chk_word(input logic [3:0] idx);
    logic [31:0] v;
    ahb(1'b1, `DSBWM_OFS_MEMIDX, {28'h0, idx}, v);
    ahb(1'b0, `DSBWM_OFS_MEMDATA, 32'h0, v);
    chk("memdata", {4'h0, mem[idx][31:0]}, {4'h0, v});
  endtask

  task automatic wr_burst(input int o, input logic [2:0] a, input logic [3:0] s0,
                          input logic [3:0] s1);
    logic [35:0] d [2];
    logic [3:0] s [2];
    logic [35:0] m;
    logic [31:0] v;
    s[0] = s0;
    s[1] = s1;
    for (int b = 0; b < 2; b++)
      d[b] = 36'({xs(), xs()});
    ctl.burst(1'b0, a, d[0], s[0], d[1], s[1]);
    for (int b = 0; b < 2; b++) begin
      m = lane_mask(o, s[b]);
      mem[{a, b[0]}] = (mem[{a, b[0]}] & ~m) | (d[b] & m);
      if (m != 36'h0) cnt++;
      chk_word({a, b[0]});
    end
    ahb(1'b0, `DSBWM_OFS_STATUS, 32'h0, v);
    chk("count", 36'(cnt), {20'h0, v[31:16]});
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cap_en = 1'b0;
    seed = 32'h000075AF;
    n_mismatch = 0;
    comparisons = 0;
    cnt = 0;
    for (int i = 0; i < 16; i++)
      mem[i] = 36'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("oe_reset", 36'h0, {35'h0, data_out_oe});
    ahb(1'b0, `DSBWM_OFS_CTRL, 32'h0, r);
    chk("ctrl", 36'h3, {4'h0, r});
    ahb(1'b0, `DSBWM_OFS_STATUS, 32'h0, r);
    chk("status", 36'h0, {4'h0, r});
    ahb(1'b0, 32'h00000010, 32'h0, r);
    chk("unmapped", 36'h0, {4'h0, r});
    // every select code as first beat, a random mask on the second
    for (int o = 0; o < 4; o++) begin
      ahb(1'b1, `DSBWM_OFS_CTRL, 32'(o), r);
      for (int i = 0; i < 16; i++) begin
        r = xs();
        wr_burst(o, r[2:0], 4'(i), r[7:4]);
      end
    end
    wr_burst(3, 3'h5, 4'h0, 4'h0);
    // single clock mode first, then the output clock pair
    for (int m = 0; m < 2; m++) begin
      ahb(1'b1, `DSBWM_OFS_CTRL, (m == 0) ? 32'h7 : 32'h3, r);
      capq.delete();
      cap_en = 1'b1;
      ctl.burst(1'b1, 3'h5, 36'h0, 4'hF, 36'h0, 4'hF);
      repeat (8) @(posedge hclk);
      cap_en = 1'b0;
      chk("read_words", 36'h2, 36'(capq.size()));
      chk("read0", mem[10], capq[0]);
      chk("read1", mem[11], capq[1]);
      chk("oe_idle", 36'h0, {35'h0, data_out_oe});
    end
    complete_run();
  end
endmodule

`default_nettype wire
